//--- core/i2c_ctl_regs.svh
`ifndef I2C_CTL_REGS_SVH
`define I2C_CTL_REGS_SVH

// register byte addresses
`define OFS_BUS_CONTROL_ONE    8'h00
`define OFS_BUS_CONTROL_TWO    8'h04
`define OFS_START_STOP_CONTROL 8'h08
`define OFS_IFACE_CONTROL      8'h0c
`define OFS_BUS_STATUS         8'h10
`define OFS_BUS_DATA           8'h14
`define OFS_IRQ_STATUS         8'h18
`define OFS_IRQ_MASK           8'h1c

// bus_control_one fields
`define B1_STOP_IRQ_EN 0
`define B1_DIV_SEL_B0  6
`define B1_DIV_SEL_B1  7

// bus_control_two fields
`define B2_TIMEOUT_EN  0
`define B2_TIMEOUT_FLG 1
`define B2_PERIOD_SEL  2
`define B2_DIV_HIGH_LO 3
`define B2_DIV_HIGH_HI 5
`define B2_STOP_FLG    7

// start_stop_control fields
`define SS_TIMING_HI   4
`define SS_POLARITY    5
`define SS_PIN_SEL     6
`define SS_GEN_SEL     7

// iface_control fields
`define IC_ENABLE      0
`define IC_CLK_SRC     1
`define IC_HIGH_SPEED  2

// bus_status fields
`define BS_MASTER      7
`define BS_TRANSMIT    6
`define BS_BUSY        5
`define BS_PENDING     4

// interrupt status and mask fields
`define IRQ_TIMEOUT    0
`define IRQ_STOP       1
`define IRQ_EDGE       2

// reset values
`define RST_BUS_CONTROL_ONE    8'h00
`define RST_BUS_CONTROL_TWO    8'h00
`define RST_START_STOP_CONTROL 8'h18
`define RST_BUS_STATUS         8'h10

// the start standby pattern of the status register
`define STATUS_START_STANDBY   8'he0

// generated set-up and hold times in interface clock cycles
`define GEN_STD_SHORT  6'd20
`define GEN_STD_LONG   6'd52
`define GEN_HS_SHORT   6'd10
`define GEN_HS_LONG    6'd26

// time-out counter end values
`define TOUT_LONG_END  16'hffff
`define TOUT_SHORT_END 14'h3fff

`endif

//--- core/i2c_ctl_pkg.sv
package i2c_ctl_pkg;

   // sampled bus lines
   typedef struct packed {
      logic scl;
      logic sda;
   } pins_type;

   // start generation and byte clocking sequence
   typedef enum logic [2:0] {
      GEN_IDLE    = 3'b000,
      GEN_STANDBY = 3'b001,
      GEN_SETUP   = 3'b010,
      GEN_HOLD    = 3'b011,
      GEN_LOW     = 3'b100,
      GEN_HIGH    = 3'b101
   } gen_state_type;

endpackage

//--- core/sync2.sv
`timescale 1ns/1ns
module sync2
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic d,
   output logic      q
);

   logic meta_r;

   // two-stage synchroniser, idles high like the bus
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_r <= 1'b1;
         q      <= 1'b1;
      end
      else
      begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule

//--- core/frac_clk_div.sv
`timescale 1ns/1ns
module frac_clk_div
#(
   parameter int WIDTH = 5
)
(
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             src_en,
   input  wire logic [WIDTH-1:0] half_div,
   output logic                  tick
);

   logic [WIDTH-1:0] acc_r;
   logic [WIDTH-1:0] acc_nxt;
   logic             hit;

   // two half steps per source cycle, so /2.5 works
   always_comb
   begin
      acc_nxt = acc_r + WIDTH'(2);
      hit     = (acc_nxt >= half_div);
      if (hit)
         acc_nxt = acc_nxt - half_div;
   end

   // accumulator and output pulse
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         acc_r <= '0;
         tick  <= 1'b0;
      end
      else
      begin
         tick <= src_en & hit;
         if (src_en)
            acc_r <= acc_nxt;
      end
   end

endmodule

//--- core/i2c_ctl.sv
`timescale 1ns/1ns
`include "i2c_ctl_regs.svh"
module i2c_ctl
   import i2c_ctl_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        clock_line_pin,
   input  wire logic        data_line_pin,
   output logic             scl_out,
   output logic             scl_oe,
   output logic             sda_out,
   output logic             sda_oe,
   input  wire logic        stop_mode,
   input  wire logic        wait_mode,
   input  wire logic        wait_clk_stop_bit,
   output logic             irq
);

   logic [7:0]    ctl_one_r;
   logic [7:0]    ctl_two_r;
   logic [7:0]    ss_ctl_r;
   logic [2:0]    iface_ctl_r;
   logic [7:0]    status_r;
   logic [7:0]    data_r;
   logic [2:0]    irq_st_r;
   logic [2:0]    irq_mask_r;
   logic          f2_en_r;
   logic          src_en;
   logic [4:0]    half_div;
   logic          tick;
   pins_type      pin_s;
   pins_type      pin_q_r;
   logic [4:0]    hi_cnt_r;
   logic          start_det;
   logic          stop_det;
   logic          edge_det;
   logic [15:0]   tout_cnt_r;
   logic          tout_hit;
   gen_state_type gen_state_r;
   logic [5:0]    gen_cnt_r;
   logic [5:0]    gen_tgt;
   logic [2:0]    bit_cnt_r;
   logic          rd_phase;
   logic          wr_en;
   logic          mapped;
   logic          enabled;
   logic          standby_req;

   // APB strobes
   assign rd_phase = psel & ~penable;
   assign wr_en    = psel & penable & pready & pwrite;
   assign enabled  = iface_ctl_r[`IC_ENABLE];

   // address decode
   always_comb
   begin
      case (paddr)
         `OFS_BUS_CONTROL_ONE,
         `OFS_BUS_CONTROL_TWO,
         `OFS_START_STOP_CONTROL,
         `OFS_IFACE_CONTROL,
         `OFS_BUS_STATUS,
         `OFS_BUS_DATA,
         `OFS_IRQ_STATUS,
         `OFS_IRQ_MASK: mapped = 1'b1;
         default:       mapped = 1'b0;
      endcase
   end

   // one wait state, error on unmapped address
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~mapped;
      end
   end

   // read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= '0;
      else if (rd_phase)
      begin
         case (paddr)
            `OFS_BUS_CONTROL_ONE:    prdata <= {24'h0, ctl_one_r};
            `OFS_BUS_CONTROL_TWO:    prdata <= {24'h0, ctl_two_r};
            `OFS_START_STOP_CONTROL: prdata <= {24'h0, ss_ctl_r};
            `OFS_IFACE_CONTROL:      prdata <= {29'h0, iface_ctl_r};
            `OFS_BUS_STATUS:         prdata <= {24'h0, status_r};
            `OFS_BUS_DATA:           prdata <= {24'h0, data_r};
            `OFS_IRQ_STATUS:         prdata <= {29'h0, irq_st_r};
            `OFS_IRQ_MASK:           prdata <= {29'h0, irq_mask_r};
            default:                 prdata <= '0;
         endcase
      end
   end

   // plain control registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctl_one_r   <= `RST_BUS_CONTROL_ONE;
         ss_ctl_r    <= `RST_START_STOP_CONTROL;
         iface_ctl_r <= 3'h0;
         irq_mask_r  <= 3'h0;
         data_r      <= 8'h00;
      end
      else if (wr_en)
      begin
         case (paddr)
            `OFS_BUS_CONTROL_ONE:    ctl_one_r   <= pwdata[7:0];
            `OFS_START_STOP_CONTROL: ss_ctl_r    <= pwdata[7:0];
            `OFS_IFACE_CONTROL:      iface_ctl_r <= pwdata[2:0];
            `OFS_IRQ_MASK:           irq_mask_r  <= pwdata[2:0];
            `OFS_BUS_DATA:           data_r      <= pwdata[7:0];
            default:                 ;
         endcase
      end
   end

   // f2 runs at half the f1 rate
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         f2_en_r <= 1'b0;
      else
         f2_en_r <= ~f2_en_r;
   end

   // clock halted in stop mode or stopped wait
   assign src_en = (iface_ctl_r[`IC_CLK_SRC] ? f2_en_r : 1'b1) &
                   ~stop_mode & ~(wait_mode & wait_clk_stop_bit);

   // divisor in half steps from the select bits
   always_comb
   begin
      case ({ctl_two_r[`B2_DIV_HIGH_HI:`B2_DIV_HIGH_LO],
             ctl_one_r[`B1_DIV_SEL_B1], ctl_one_r[`B1_DIV_SEL_B0]})
         5'b00000: half_div = 5'd4;
         5'b00001: half_div = 5'd8;
         5'b00010: half_div = 5'd16;
         5'b00100, 5'b00101, 5'b00110, 5'b00111: half_div = 5'd5;
         5'b01000, 5'b01001, 5'b01010, 5'b01011: half_div = 5'd6;
         5'b01100, 5'b01101, 5'b01110, 5'b01111: half_div = 5'd10;
         5'b10000, 5'b10001, 5'b10010, 5'b10011: half_div = 5'd12;
         default:  half_div = 5'd4;
      endcase
   end

   frac_clk_div #(.WIDTH(5)) u_div
   (
      .pclk     (pclk),
      .presetn  (presetn),
      .src_en   (src_en),
      .half_div (half_div),
      .tick     (tick)
   );

   sync2 u_sync_scl
   (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (clock_line_pin),
      .q       (pin_s.scl)
   );

   sync2 u_sync_sda
   (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (data_line_pin),
      .q       (pin_s.sda)
   );

   // line history and stable-high count per tick
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_q_r  <= '{scl: 1'b1, sda: 1'b1};
         hi_cnt_r <= 5'd0;
      end
      else if (tick)
      begin
         pin_q_r <= pin_s;
         if (!pin_s.scl || pin_s.sda != pin_q_r.sda)
            hi_cnt_r <= 5'd0;
         else if (hi_cnt_r != 5'h1f)
            hi_cnt_r <= hi_cnt_r + 5'd1;
      end
   end

   // detection live as soon as enabled
   always_comb
   begin
      start_det = 1'b0;
      stop_det  = 1'b0;
      if (tick && enabled && pin_s.scl && pin_q_r.scl &&
          hi_cnt_r >= {1'b0, ss_ctl_r[`SS_TIMING_HI:1]})
      begin
         start_det = pin_q_r.sda & ~pin_s.sda;
         stop_det  = ~pin_q_r.sda & pin_s.sda;
      end
   end

   // edge on chosen pin with chosen polarity
   always_comb
   begin
      if (ss_ctl_r[`SS_PIN_SEL])
         edge_det = ss_ctl_r[`SS_POLARITY] ?
                    (pin_s.sda & ~pin_q_r.sda) :
                    (~pin_s.sda & pin_q_r.sda);
      else
         edge_det = ss_ctl_r[`SS_POLARITY] ?
                    (pin_s.scl & ~pin_q_r.scl) :
                    (~pin_s.scl & pin_q_r.scl);
      edge_det = edge_det & tick & enabled;
   end

   // restart on low clock, free bus or disable
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tout_cnt_r <= 16'h0;
      else if (!enabled || !status_r[`BS_BUSY] || !pin_s.scl ||
               !ctl_two_r[`B2_TIMEOUT_EN])
         tout_cnt_r <= 16'h0;
      else if (tick)
         tout_cnt_r <= tout_hit ? 16'h0 : tout_cnt_r + 16'h1;
   end

   // overflow at 16 or 14 bits
   assign tout_hit = tick && enabled && status_r[`BS_BUSY] &&
                     pin_s.scl && ctl_two_r[`B2_TIMEOUT_EN] &&
                     (ctl_two_r[`B2_PERIOD_SEL] ?
                      (tout_cnt_r[13:0] == `TOUT_SHORT_END) :
                      (tout_cnt_r == `TOUT_LONG_END));

   // control two with set-wins flags
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctl_two_r <= `RST_BUS_CONTROL_TWO;
      else
      begin
         if (wr_en && paddr == `OFS_BUS_CONTROL_TWO)
         begin
            ctl_two_r[6:0] <= {pwdata[6:2], ctl_two_r[`B2_TIMEOUT_FLG],
                               pwdata[0]};
            // write 0 clears, write 1 keeps
            if (!pwdata[`B2_STOP_FLG])
               ctl_two_r[`B2_STOP_FLG] <= 1'b0;
            if (!pwdata[`B2_TIMEOUT_FLG])
               ctl_two_r[`B2_TIMEOUT_FLG] <= 1'b0;
         end
         if (tout_hit)
            ctl_two_r[`B2_TIMEOUT_FLG] <= 1'b1;
         // stop flag when stop raises interrupt
         if (stop_det && ctl_one_r[`B1_STOP_IRQ_EN])
            ctl_two_r[`B2_STOP_FLG] <= 1'b1;
      end
   end

   // interrupt status, write one to clear, set wins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_st_r <= 3'h0;
      else
      begin
         if (wr_en && paddr == `OFS_IRQ_STATUS)
            irq_st_r <= irq_st_r & ~pwdata[2:0];
         if (tout_hit)
            irq_st_r[`IRQ_TIMEOUT] <= 1'b1;
         if (stop_det && ctl_one_r[`B1_STOP_IRQ_EN])
            irq_st_r[`IRQ_STOP] <= 1'b1;
         if (edge_det)
            irq_st_r[`IRQ_EDGE] <= 1'b1;
      end
   end

   // level interrupt from unmasked status
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq <= 1'b0;
      else
         irq <= |(irq_st_r & irq_mask_r);
   end

   // exact standby pattern on enabled free bus
   assign standby_req = wr_en && paddr == `OFS_BUS_STATUS &&
                        pwdata[7:0] == `STATUS_START_STANDBY &&
                        enabled && !status_r[`BS_BUSY];

   // bus status register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         status_r <= `RST_BUS_STATUS;
      else if (!enabled)
         status_r <= `RST_BUS_STATUS;
      else
      begin
         if (wr_en && paddr == `OFS_BUS_STATUS)
         begin
            status_r[7:6] <= pwdata[7:6];
            status_r[4:0] <= pwdata[4:0];
            if (standby_req)
               status_r[`BS_BUSY] <= 1'b1;
         end
         // busy follows detected start and stop
         if (start_det)
            status_r[`BS_BUSY] <= 1'b1;
         if (stop_det)
         begin
            status_r[`BS_BUSY]     <= 1'b0;
            status_r[`BS_MASTER]   <= 1'b0;
            status_r[`BS_TRANSMIT] <= 1'b0;
         end
         // byte sent, request pending service
         if (tick && gen_state_r == GEN_HIGH && bit_cnt_r == 3'd7 &&
             gen_cnt_r == gen_tgt)
            status_r[`BS_PENDING] <= 1'b0;
      end
   end

   always_comb
   begin
      if (iface_ctl_r[`IC_HIGH_SPEED])
         gen_tgt = ss_ctl_r[`SS_GEN_SEL] ? `GEN_HS_LONG : `GEN_HS_SHORT;
      else
         gen_tgt = ss_ctl_r[`SS_GEN_SEL] ? `GEN_STD_LONG : `GEN_STD_SHORT;
   end

   // start generation and byte clocking
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gen_state_r <= GEN_IDLE;
         gen_cnt_r   <= 6'd0;
         bit_cnt_r   <= 3'd0;
         scl_oe      <= 1'b0;
         sda_oe      <= 1'b0;
         scl_out     <= 1'b0;
         sda_out     <= 1'b0;
      end
      else if (!enabled)
      begin
         gen_state_r <= GEN_IDLE;
         gen_cnt_r   <= 6'd0;
         scl_oe      <= 1'b0;
         sda_oe      <= 1'b0;
      end
      else
      begin
         case (gen_state_r)
            GEN_IDLE:
            begin
               if (standby_req)
               begin
                  gen_state_r <= GEN_STANDBY;
                  scl_oe      <= 1'b0;
                  sda_oe      <= 1'b0;
               end
            end
            GEN_STANDBY:
            begin
               if (wr_en && paddr == `OFS_BUS_DATA)
               begin
                  gen_state_r <= GEN_SETUP;
                  gen_cnt_r   <= 6'd0;
               end
               else if (start_det)
                  gen_state_r <= GEN_IDLE;
            end
            GEN_SETUP, GEN_HOLD, GEN_LOW, GEN_HIGH:
            begin
               if (tick)
               begin
                  gen_cnt_r <= gen_cnt_r + 6'd1;
                  if (gen_cnt_r == gen_tgt)
                  begin
                     gen_cnt_r <= 6'd0;
                     case (gen_state_r)
                        GEN_SETUP:
                        begin
                           sda_oe      <= 1'b1;
                           gen_state_r <= GEN_HOLD;
                        end
                        GEN_HOLD:
                        begin
                           scl_oe      <= 1'b1;
                           bit_cnt_r   <= 3'd0;
                           gen_state_r <= GEN_LOW;
                        end
                        GEN_LOW:
                        begin
                           scl_oe      <= 1'b0;
                           gen_state_r <= GEN_HIGH;
                        end
                        default:
                        begin
                           scl_oe    <= 1'b1;
                           bit_cnt_r <= bit_cnt_r + 3'd1;
                           if (bit_cnt_r == 3'd7)
                              gen_state_r <= GEN_IDLE;
                           else
                              gen_state_r <= GEN_LOW;
                        end
                     endcase
                  end
                  // data bit set while the clock is low
                  if (gen_state_r == GEN_LOW && gen_cnt_r == 6'd0)
                     sda_oe <= ~data_r[3'd7 - bit_cnt_r];
               end
            end
            default:
               gen_state_r <= GEN_IDLE;
         endcase
      end
   end

endmodule

//--- dv/i2c_ctl_chk.sv
`timescale 1ns/1ns
module i2c_ctl_chk
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        scl_out,
   input wire logic        scl_oe,
   input wire logic        sda_out,
   input wire logic        sda_oe,
   input wire logic        irq
);
   logic mapped;

   // decode of the eight word addresses
   assign mapped = paddr <= 8'h1c && paddr[1:0] == 2'b00;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // bus answer timing and decode
   apb_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("pready not on second access cycle");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   ready_access_a: assert property (pready |-> psel && penable)
      else $error("pready outside an access");
   err_decode_a: assert property (pready |-> pslverr == !mapped)
      else $error("pslverr does not match address map");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   err_rdata_a: assert property (pready && pslverr && !pwrite |->
      prdata == 32'h0)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (psel && penable && $past(penable) |->
      $stable(prdata))
      else $error("prdata moved during access");
   // open drain lines only ever pull low
   od_value_a: assert property (!scl_out && !sda_out)
      else $error("line output value not zero");
   start_hold_a: assert property ($rose(sda_oe) && !scl_oe |=>
      !scl_oe [*8])
      else $error("start hold too short");

   // main scenarios reached
   cover property (pready && pslverr);
   cover property ($rose(scl_oe));
   cover property ($rose(irq));
endmodule

//--- dv/i2c_bus_model.sv
`timescale 1ns/1ns
module i2c_bus_model
(
   input  wire logic pclk,
   input  wire logic scl_oe,
   input  wire logic sda_oe,
   output logic      clock_line_pin,
   output logic      data_line_pin
);
   logic scl_low = 1'b0;
   logic sda_low = 1'b0;

   // pulled-up wires, low while any party drives
   assign clock_line_pin = ~(scl_oe | scl_low);
   assign data_line_pin  = ~(sda_oe | sda_low);

   // far master changes lines after an edge, then holds them
   task automatic line_set(input logic c, input logic d, input int n);
      @(posedge pclk);
      scl_low <= c;
      sda_low <= d;
      repeat (n) @(posedge pclk);
   endtask
endmodule

//--- dv/tb.sv
`timescale 1ns/1ns
`include "i2c_ctl_regs.svh"
module tb;
   typedef struct packed {
      logic [7:0] one;
      logic [7:0] two;
      logic [7:0] ifc;
      logic [7:0] ss;
      logic [7:0] gap;
   } row_type;
   logic        pclk = 1'b0;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        clock_line_pin;
   logic        data_line_pin;
   logic        scl_out;
   logic        scl_oe;
   logic        sda_out;
   logic        sda_oe;
   logic        stop_mode;
   logic        wait_mode;
   logic        wait_clk_stop_bit;
   logic        irq;
   logic [31:0] rdv;
   logic        errv;
   int          err_total = 0;
   int          checks = 0;
   int          cyc = 0;
   int          c;
   // gap = (set-up cycles + 1) * divisor, in pclk cycles
   row_type     rows [10] = '{
      '{8'h00, 8'h00, 8'h01, 8'h18, 8'h2a}, '{8'h00, 8'h00, 8'h01, 8'h98, 8'h6a},
      '{8'h00, 8'h00, 8'h05, 8'h18, 8'h16}, '{8'h00, 8'h00, 8'h05, 8'h98, 8'h36},
      '{8'h40, 8'h00, 8'h01, 8'h18, 8'h54}, '{8'h80, 8'h00, 8'h01, 8'h18, 8'ha8},
      '{8'h00, 8'h10, 8'h01, 8'h18, 8'h3f}, '{8'h00, 8'h18, 8'h01, 8'h18, 8'h69},
      '{8'h00, 8'h20, 8'h01, 8'h18, 8'h7e}, '{8'h00, 8'h00, 8'h03, 8'h18, 8'h54}};

   i2c_ctl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .clock_line_pin, .data_line_pin,
      .scl_out, .scl_oe, .sda_out, .sda_oe, .stop_mode, .wait_mode,
      .wait_clk_stop_bit, .irq);
   i2c_bus_model i_bus (.pclk, .scl_oe, .sda_oe, .clock_line_pin,
      .data_line_pin);

   // free running bus clock
   always #5 pclk = ~pclk;

   // cycle ceiling against hangs
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         err_total++;
         test_done();
      end
   end

   // compare and count
   task automatic chk(input string nm, input logic [31:0] s,
      input logic [31:0] e);
      checks++;
      if (s !== e)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask

   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      chk("pready", {31'h0, pready}, 32'h1);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask

   // pclk cycles from start data low to first clock low
   task automatic gap(output int g);
      int n;
      n = 0;
      g = 0;
      while (sda_oe !== 1'b1 && n < 2000)
      begin
         @(posedge pclk);
         n++;
      end
      while (scl_oe !== 1'b1 && g < 2000)
      begin
         @(posedge pclk);
         g++;
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // main sequence
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      stop_mode = 1'b0;
      wait_mode = 1'b1;
      wait_clk_stop_bit = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i])
      begin
         wr(`OFS_BUS_CONTROL_ONE, {24'h0, rows[i].one});
         wr(`OFS_BUS_CONTROL_TWO, {24'h0, rows[i].two});
         wr(`OFS_START_STOP_CONTROL, {24'h0, rows[i].ss});
         wr(`OFS_IFACE_CONTROL, {24'h0, rows[i].ifc});
         wr(`OFS_BUS_STATUS, {24'h0, `STATUS_START_STANDBY});
         rd(`OFS_BUS_STATUS);
         chk("standby", rdv, 32'he0);
         wr(`OFS_BUS_DATA, 32'ha5);
         gap(c);
         chk("gen_gap", c, {24'h0, rows[i].gap});
         wr(`OFS_IFACE_CONTROL, 32'h0);
      end
      $display("test rows done");
      // clock halted in stop and in wait with clock stop
      wr(`OFS_IFACE_CONTROL, 32'h1);
      wr(`OFS_BUS_STATUS, {24'h0, `STATUS_START_STANDBY});
      wr(`OFS_BUS_DATA, 32'ha5);
      @(posedge pclk);
      stop_mode <= 1'b1;
      repeat (200) @(posedge pclk);
      chk("halt_stop", {31'h0, sda_oe}, 32'h0);
      stop_mode <= 1'b0;
      wait_clk_stop_bit <= 1'b1;
      repeat (200) @(posedge pclk);
      chk("halt_wait", {31'h0, sda_oe}, 32'h0);
      wait_clk_stop_bit <= 1'b0;
      gap(c);
      chk("wait_run", c, 32'h2a);
      wr(`OFS_IFACE_CONTROL, 32'h0);
      $display("test halt done");
      wr(`OFS_IFACE_CONTROL, 32'h1);
      wr(`OFS_BUS_CONTROL_TWO, 32'h05);
      wr(`OFS_IRQ_MASK, 32'h1);
      // lines idle long enough for the release time
      i_bus.line_set(1'b0, 1'b0, 40);
      i_bus.line_set(1'b0, 1'b1, 200);
      rd(`OFS_BUS_STATUS);
      chk("busy_set", rdv & 32'h20, 32'h20);
      repeat (20000) @(posedge pclk);
      i_bus.line_set(1'b1, 1'b1, 10);
      i_bus.line_set(1'b0, 1'b1, 30000);
      rd(`OFS_BUS_CONTROL_TWO);
      chk("no_tout", rdv & 32'h2, 32'h0);
      c = 0;
      while (irq !== 1'b1 && c < 6000)
      begin
         @(posedge pclk);
         c++;
      end
      chk("tout_irq", {31'h0, c < 6000}, 32'h1);
      rd(`OFS_IRQ_STATUS);
      chk("tout_stat", rdv & 32'h1, 32'h1);
      // stop flag, write one keeps, write zero clears
      wr(`OFS_BUS_CONTROL_ONE, 32'h1);
      i_bus.line_set(1'b1, 1'b1, 100);
      i_bus.line_set(1'b0, 1'b1, 100);
      i_bus.line_set(1'b0, 1'b0, 200);
      rd(`OFS_BUS_STATUS);
      chk("busy_clr", rdv & 32'h20, 32'h0);
      wr(`OFS_BUS_CONTROL_TWO, 32'h86);
      rd(`OFS_BUS_CONTROL_TWO);
      chk("flags_keep", rdv & 32'h82, 32'h82);
      wr(`OFS_BUS_CONTROL_TWO, 32'h04);
      rd(`OFS_BUS_CONTROL_TWO);
      chk("flags_clr", rdv & 32'h82, 32'h0);
      wr(`OFS_IRQ_STATUS, 32'h7);
      wr(`OFS_IFACE_CONTROL, 32'h0);
      rd(`OFS_BUS_STATUS);
      chk("disable", rdv, {24'h0, `RST_BUS_STATUS});
      chk("irq_low", {31'h0, irq}, 32'h0);
      $display("test timeout done");
      // every pin and polarity, masked while set up
      wr(`OFS_IFACE_CONTROL, 32'h1);
      for (int k = 0; k < 4; k++)
      begin
         i_bus.line_set(!k[1] & k[0], k[1] & k[0], 20);
         wr(`OFS_IRQ_MASK, 32'h0);
         wr(`OFS_START_STOP_CONTROL, {24'h0, 1'b0, k[1], k[0], 5'h18});
         wr(`OFS_IRQ_STATUS, 32'h7);
         wr(`OFS_IRQ_MASK, 32'h4);
         rd(`OFS_IRQ_STATUS);
         chk("edge_none", rdv & 32'h4, 32'h0);
         i_bus.line_set(!k[1] & !k[0], k[1] & !k[0], 20);
         rd(`OFS_IRQ_STATUS);
         chk("edge_set", rdv & 32'h4, 32'h4);
         chk("edge_irq", {31'h0, irq}, 32'h1);
      end
      wr(`OFS_IRQ_MASK, 32'h0);
      repeat (2) @(posedge pclk);
      chk("edge_mask", {31'h0, irq}, 32'h0);
      $display("test edge done");
      // reset values, read write, unmapped place
      presetn <= 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd(`OFS_START_STOP_CONTROL);
      chk("rst_ss", rdv, {24'h0, `RST_START_STOP_CONTROL});
      rd(`OFS_BUS_CONTROL_TWO);
      chk("rst_two", rdv, {24'h0, `RST_BUS_CONTROL_TWO});
      rd(`OFS_BUS_STATUS);
      chk("rst_stat", rdv, {24'h0, `RST_BUS_STATUS});
      wr(`OFS_START_STOP_CONTROL, 32'h5a);
      rd(`OFS_START_STOP_CONTROL);
      chk("ss_rw", rdv, 32'h5a);
      rd(8'h20);
      chk("unmapped", {errv, rdv[30:0]}, 32'h80000000);
      $display("test registers done");
      test_done();
   end
endmodule

bind i2c_ctl i2c_ctl_chk i_chk
(
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
   .pready, .pslverr, .scl_out, .scl_oe, .sda_out, .sda_oe, .irq
);
